//--- design/spp_pkg.sv
package spp_pkg;
   // ----------------------------------------------------------------
   // register map (index on the plain register port)
   // ----------------------------------------------------------------
   localparam logic [1:0] OFS_STATUS = 2'h0;
   localparam logic [1:0] OFS_CTRL1 = 2'h1;
   localparam logic [1:0] OFS_CTRL2 = 2'h2;
   localparam logic [1:0] OFS_DATA = 2'h3;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ST_ENABLE = 15;
   localparam int ST_IDLE_STOP = 13;
   localparam int ST_OVERFLOW = 6;
   localparam int ST_TX_FULL = 1;
   localparam int ST_RX_FULL = 0;
   localparam int C1_DIS_CLOCK = 12;
   localparam int C1_DIS_DATA = 11;
   localparam int C1_WIDE = 10;
   localparam int C1_LATE = 9;
   localparam int C1_EDGE = 8;
   localparam int C1_SEL_EN = 7;
   localparam int C1_POL = 6;
   localparam int C1_MASTER = 5;
   localparam int C1_DIV_LSB = 0;
   localparam int DIV_WIDTH = 3;
   localparam int C2_FRAMED = 15;
   localparam int C2_SYNC_IN = 14;
   localparam int C2_SYNC_POL = 13;
   localparam int C2_SYNC_LATE = 1;
   localparam logic [15:0] CTRL1_WMASK = 16'h1FE7;
   localparam logic [15:0] CTRL2_WMASK = 16'hE002;

   // ----------------------------------------------------------------
   // reset values and sizes
   // ----------------------------------------------------------------
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [4:0] WORD_BITS = 5'h10;
   localparam logic [4:0] BYTE_BITS = 5'h08;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLOCK_NS = 40;
   localparam int LINK_PERIOD_NS = 320;
   localparam int LINK_HALF_CYC = (LINK_PERIOD_NS / 2) / CLOCK_NS;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_SYNC = 3'b010,
      SEQ_RUN = 3'b100
   } spp_seq_t;
endpackage : spp_pkg

//--- design/spp_link_if.sv
`timescale 1ns/1ps
interface spp_link_if;
   logic devSckO;
   logic devSckOeN;
   logic devSsO;
   logic devSsOeN;
   logic devSdo;
   logic devSdoOeN;
   logic partSckO;
   logic partSckOeN;
   logic partSsO;
   logic partSsOeN;
   logic partSdo;
   logic partSdoOeN;
   logic sck;
   logic ss;
   logic devSdi;
   logic partSdi;

   // ----------------------------------------------------------------
   // wire resolution, undriven lines are pulled high
   // ----------------------------------------------------------------
   assign sck = !devSckOeN ? devSckO : (!partSckOeN ? partSckO : 1'h1);
   assign ss = !devSsOeN ? devSsO : (!partSsOeN ? partSsO : 1'h1);
   assign devSdi = !partSdoOeN ? partSdo : 1'h1;
   assign partSdi = !devSdoOeN ? devSdo : 1'h1;

   modport dev (output devSckO, devSckOeN, devSsO, devSsOeN, devSdo, devSdoOeN, input sck, ss, devSdi);
   modport part (output partSckO, partSckOeN, partSsO, partSsOeN, partSdo, partSdoOeN, input sck, ss, partSdi);
endinterface : spp_link_if

//--- design/spp_device_end.sv
`timescale 1ns/1ps
module spp_device_end (
   input wire logic clock, // module clock
   input wire logic nrst, // asynchronous reset
   input wire logic idleMode, // device is in idle mode
   input wire logic [1:0] regAddr, // register index
   input wire logic [15:0] regWdata, // write data
   input wire logic regWr, // write strobe
   input wire logic regRd, // read strobe
   output logic [15:0] regRdata, // read data, cycle after the strobe
   spp_link_if.dev link // serial pins
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic enable_r, idleStop_r, overflow_r, txFull_r, rxFull_r, txLoaded_r;
   logic [15:0] ctrl1_r, ctrl2_r, txHold_r, rxHold_r, txShift_r, rxShift_r, statusView, rxWord;
   logic [2:0] sckSync_r;
   logic [1:0] ssSync_r, sdiSync_r;
   logic [4:0] bitCnt_r, wordLen;
   logic [5:0] halfCnt_r, kCnt_r, halfLoad;
   logic sckOut_r, sdo_r, ssOut_r, fsync_r, fsync_nxt;
   spp_pkg::spp_seq_t seq_r;
   logic wide, late, edgeSel, selEn, cpol, master, framed, syncIn, syncPol, syncLate, run;
   logic slaveLead, slaveTrail, tick, lead, trail, selected, sampleOnLead, inWord;
   logic sampleEv, changeEv, wordDone, frameReq, startMaster, startFrame, preload, loadTx;
   logic wrStatus, wrData, rdData, rxSet;

   assign wide = ctrl1_r[spp_pkg::C1_WIDE];
   assign late = ctrl1_r[spp_pkg::C1_LATE];
   assign edgeSel = ctrl1_r[spp_pkg::C1_EDGE];
   assign selEn = ctrl1_r[spp_pkg::C1_SEL_EN];
   assign cpol = ctrl1_r[spp_pkg::C1_POL];
   assign master = ctrl1_r[spp_pkg::C1_MASTER];
   assign framed = ctrl2_r[spp_pkg::C2_FRAMED];
   assign syncIn = ctrl2_r[spp_pkg::C2_SYNC_IN];
   assign syncPol = ctrl2_r[spp_pkg::C2_SYNC_POL];
   assign syncLate = ctrl2_r[spp_pkg::C2_SYNC_LATE];
   assign run = enable_r & ~(idleStop_r & idleMode);
   assign wordLen = wide ? spp_pkg::WORD_BITS : spp_pkg::BYTE_BITS;
   assign halfLoad = 6'(({3'h0, ctrl1_r[spp_pkg::C1_DIV_LSB +: spp_pkg::DIV_WIDTH]} + 6'h01)
                     * 6'(spp_pkg::LINK_HALF_CYC)) - 6'h01;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sckSync_r <= 3'h0;
         ssSync_r <= 2'h3;
         sdiSync_r <= 2'h0;
      end else begin
         sckSync_r <= {sckSync_r[1:0], link.sck};
         ssSync_r <= {ssSync_r[0], link.ss};
         sdiSync_r <= {sdiSync_r[0], link.devSdi};
      end
   end

   // ----------------------------------------------------------------
   // clock events
   // ----------------------------------------------------------------
   assign slaveLead = (sckSync_r[1] != sckSync_r[2]) & (sckSync_r[2] == cpol);
   assign slaveTrail = (sckSync_r[1] != sckSync_r[2]) & (sckSync_r[2] != cpol);
   assign inWord = seq_r == spp_pkg::SEQ_RUN;
   assign tick = (halfCnt_r == 6'h00) & (framed | inWord);
   assign selected = framed | ~selEn | ~ssSync_r[1];
   assign lead = run & (master ? tick & (sckOut_r == cpol) : slaveLead & selected);
   assign trail = run & (master ? tick & (sckOut_r != cpol) : slaveTrail & selected);
   // a slave always samples mid-bit; late sampling is a master-only option
   assign sampleOnLead = master ? edgeSel ^ late : edgeSel;
   assign sampleEv = inWord & (sampleOnLead ? lead : trail)
                     & ~(master & late & ~framed & kCnt_r == 6'h00);
   assign changeEv = inWord & (edgeSel ? trail : lead);
   assign wordDone = sampleEv & (bitCnt_r == wordLen - 5'h01);
   assign rxWord = wide ? {rxShift_r[14:0], sdiSync_r[1]} : {8'h00, rxShift_r[6:0], sdiSync_r[1]};

   // ----------------------------------------------------------------
   // word sequencer
   // ----------------------------------------------------------------
   assign frameReq = master ? txFull_r : (ssSync_r[1] == syncPol);
   assign startMaster = (seq_r == spp_pkg::SEQ_IDLE) & ~framed & master & txFull_r;
   assign startFrame = framed & lead & (((seq_r == spp_pkg::SEQ_IDLE) & frameReq & syncLate)
                       | (seq_r == spp_pkg::SEQ_SYNC));
   assign preload = ~master & ~framed & (bitCnt_r == 5'h00) & ~txLoaded_r & txFull_r;
   assign loadTx = run & (startMaster | startFrame | preload);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         seq_r <= spp_pkg::SEQ_IDLE;
      end else if (!enable_r) begin
         seq_r <= spp_pkg::SEQ_IDLE;
      end else if (run) begin
         unique case (seq_r)
            spp_pkg::SEQ_IDLE: begin
               if (!framed && (!master || txFull_r)) begin
                  seq_r <= spp_pkg::SEQ_RUN;
               end else if (framed && lead && frameReq) begin
                  seq_r <= syncLate ? spp_pkg::SEQ_RUN : spp_pkg::SEQ_SYNC;
               end
            end
            spp_pkg::SEQ_SYNC: begin
               if (lead) begin
                  seq_r <= spp_pkg::SEQ_RUN;
               end
            end
            spp_pkg::SEQ_RUN: begin
               if (framed ? wordDone : master & tick & (kCnt_r == {wordLen, 1'h0})) begin
                  seq_r <= spp_pkg::SEQ_IDLE;
               end
            end
            default: seq_r <= spp_pkg::SEQ_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // master clock generator
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         halfCnt_r <= 6'h00;
         kCnt_r <= 6'h00;
         sckOut_r <= 1'h0;
      end else if (!enable_r || !master) begin
         halfCnt_r <= 6'h00;
         kCnt_r <= 6'h00;
         sckOut_r <= cpol;
      end else if (run) begin
         if (framed || inWord) begin
            if (tick) begin
               halfCnt_r <= halfLoad;
               kCnt_r <= kCnt_r + 6'h01;
               if (framed || kCnt_r < {wordLen, 1'h0}) begin
                  sckOut_r <= ~sckOut_r;
               end
            end else begin
               halfCnt_r <= halfCnt_r - 6'h01;
            end
         end else begin
            halfCnt_r <= halfLoad;
            kCnt_r <= 6'h00;
            sckOut_r <= cpol;
         end
      end
   end

   // ----------------------------------------------------------------
   // shift engine
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         txShift_r <= spp_pkg::WORD_RESET;
         rxShift_r <= spp_pkg::WORD_RESET;
         bitCnt_r <= 5'h00;
         txLoaded_r <= 1'h0;
      end else if (!enable_r) begin
         bitCnt_r <= 5'h00;
         txLoaded_r <= 1'h0;
      end else if (run) begin
         if (loadTx) begin
            txShift_r <= txFull_r ? txHold_r : spp_pkg::WORD_RESET;
            txLoaded_r <= 1'h1;
         end else if (changeEv && (bitCnt_r != 5'h00 || sampleEv)) begin
            txShift_r <= {txShift_r[14:0], 1'h0};
         end
         if (sampleEv) begin
            rxShift_r <= {rxShift_r[14:0], sdiSync_r[1]};
            bitCnt_r <= wordDone ? 5'h00 : bitCnt_r + 5'h01;
         end
         if (wordDone) begin
            txLoaded_r <= 1'h0;
         end
      end
   end

   // ----------------------------------------------------------------
   // pin drivers
   // ----------------------------------------------------------------
   // the sync pulse lasts from the lead edge that starts it until the next lead edge
   assign fsync_nxt = lead ? framed & (seq_r == spp_pkg::SEQ_IDLE) & frameReq : fsync_r;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         fsync_r <= 1'h0;
         ssOut_r <= 1'h1;
         sdo_r <= 1'h0;
      end else begin
         fsync_r <= enable_r & fsync_nxt;
         ssOut_r <= framed ? (fsync_nxt ? syncPol : ~syncPol) : ~inWord;
         sdo_r <= wide ? txShift_r[15] : txShift_r[7];
      end
   end

   // output enables are low while this end drives the pin
   assign link.devSckO = sckOut_r;
   assign link.devSckOeN = ~(enable_r & master & ~ctrl1_r[spp_pkg::C1_DIS_CLOCK]);
   assign link.devSdo = sdo_r;
   assign link.devSdoOeN = ~(enable_r & ~ctrl1_r[spp_pkg::C1_DIS_DATA]);
   assign link.devSsO = ssOut_r;
   assign link.devSsOeN = ~(enable_r & master & (framed ? ~syncIn : selEn));

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   assign wrStatus = regWr & (regAddr == spp_pkg::OFS_STATUS);
   assign wrData = regWr & (regAddr == spp_pkg::OFS_DATA);
   assign rdData = regRd & (regAddr == spp_pkg::OFS_DATA);
   assign rxSet = wordDone & ~rxFull_r;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         enable_r <= 1'h0;
         idleStop_r <= 1'h0;
         ctrl1_r <= spp_pkg::CTRL_RESET;
         ctrl2_r <= spp_pkg::CTRL_RESET;
         txHold_r <= spp_pkg::WORD_RESET;
      end else if (regWr) begin
         if (wrStatus) begin
            enable_r <= regWdata[spp_pkg::ST_ENABLE];
            idleStop_r <= regWdata[spp_pkg::ST_IDLE_STOP];
         end
         if (regAddr == spp_pkg::OFS_CTRL1) begin
            ctrl1_r <= regWdata & spp_pkg::CTRL1_WMASK;
            ctrl1_r[spp_pkg::C1_LATE] <= regWdata[spp_pkg::C1_LATE] & regWdata[spp_pkg::C1_MASTER];
         end
         if (regAddr == spp_pkg::OFS_CTRL2) begin
            ctrl2_r <= regWdata & spp_pkg::CTRL2_WMASK;
         end
         if (wrData) begin
            txHold_r <= regWdata;
         end
      end
   end

   // hardware sets win over the clears issued in the same cycle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         txFull_r <= 1'h0;
         rxFull_r <= 1'h0;
         overflow_r <= 1'h0;
         rxHold_r <= spp_pkg::WORD_RESET;
      end else begin
         txFull_r <= wrData | (txFull_r & ~loadTx);
         rxFull_r <= rxSet | (rxFull_r & ~rdData);
         overflow_r <= (wordDone & rxFull_r) | (overflow_r & ~(wrStatus & ~regWdata[spp_pkg::ST_OVERFLOW]));
         if (rxSet) begin
            rxHold_r <= rxWord;
         end
      end
   end

   always_comb begin
      statusView = spp_pkg::STATUS_RESET;
      statusView[spp_pkg::ST_ENABLE] = enable_r;
      statusView[spp_pkg::ST_IDLE_STOP] = idleStop_r;
      statusView[spp_pkg::ST_OVERFLOW] = overflow_r;
      statusView[spp_pkg::ST_TX_FULL] = txFull_r;
      statusView[spp_pkg::ST_RX_FULL] = rxFull_r;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         regRdata <= 16'h0000;
      end else if (regRd) begin
         unique case (regAddr)
            spp_pkg::OFS_STATUS: regRdata <= statusView;
            spp_pkg::OFS_CTRL1: regRdata <= ctrl1_r;
            spp_pkg::OFS_CTRL2: regRdata <= ctrl2_r;
            spp_pkg::OFS_DATA: regRdata <= rxHold_r;
         endcase
      end else begin
         regRdata <= 16'h0000;
      end
   end
endmodule : spp_device_end

//--- design/spp_partner_end.sv
`timescale 1ns/1ps
module spp_partner_end (
   input wire logic clock, // module clock
   input wire logic nrst, // asynchronous reset
   input wire logic cfgMaster, // 1 = this end makes the clock
   input wire logic cfgCpol, // idle clock level
   input wire logic cfgEdge, // 1 = data changes active to idle
   input wire logic cfgWide, // 1 = 16-bit words
   input wire logic cfgFramed, // framed operation
   input wire logic cfgSyncPol, // active level of the sync pulse
   input wire logic cfgUseSelect, // slave honours the select line
   input wire logic [15:0] txWord, // word to send
   input wire logic txLoad, // pulse: latch txWord
   output logic txPending, // latched word not yet moved out
   output logic [15:0] rxWord, // last received word
   output logic rxValid, // pulse: rxWord updated
   spp_link_if.part link // serial pins
);
   logic [15:0] txHold_r, txShift_r, rxShift_r;
   logic [2:0] sckSync_r;
   logic [1:0] ssSync_r, sdiSync_r;
   logic [4:0] bitCnt_r, wordLen;
   logic [5:0] halfCnt_r, kCnt_r;
   logic sckOut_r, sdo_r, ssOut_r, loaded_r;
   spp_pkg::spp_seq_t seq_r;
   logic inWord, tick, lead, trail, sampleEv, changeEv, wordDone, frameReq, loadTx, edgeSeen;

   assign wordLen = cfgWide ? spp_pkg::WORD_BITS : spp_pkg::BYTE_BITS;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sckSync_r <= 3'h0;
         ssSync_r <= 2'h3;
         sdiSync_r <= 2'h0;
      end else begin
         sckSync_r <= {sckSync_r[1:0], link.sck};
         ssSync_r <= {ssSync_r[0], link.ss};
         sdiSync_r <= {sdiSync_r[0], link.partSdi};
      end
   end

   // ----------------------------------------------------------------
   // events; as master this end always samples late to ride out the
   // synchroniser delay of a slave answering on the far side
   // ----------------------------------------------------------------
   assign inWord = seq_r == spp_pkg::SEQ_RUN;
   assign tick = (halfCnt_r == 6'h00) & (cfgFramed | inWord);
   assign edgeSeen = (sckSync_r[1] != sckSync_r[2]) & (cfgFramed | ~cfgUseSelect | ~ssSync_r[1]);
   assign lead = cfgMaster ? tick & (sckOut_r == cfgCpol) : edgeSeen & (sckSync_r[2] == cfgCpol);
   assign trail = cfgMaster ? tick & (sckOut_r != cfgCpol) : edgeSeen & (sckSync_r[2] != cfgCpol);
   assign sampleEv = inWord & ((cfgEdge ^ cfgMaster) ? lead : trail)
                     & ~(cfgMaster & ~cfgFramed & kCnt_r == 6'h00);
   assign changeEv = inWord & (cfgEdge ? trail : lead);
   assign wordDone = sampleEv & (bitCnt_r == wordLen - 5'h01);
   assign frameReq = cfgMaster ? txPending : (ssSync_r[1] == cfgSyncPol);
   assign loadTx = ((seq_r == spp_pkg::SEQ_IDLE) & ~cfgFramed & cfgMaster & txPending)
                   | ((seq_r == spp_pkg::SEQ_SYNC) & lead)
                   | (~cfgMaster & ~cfgFramed & (bitCnt_r == 5'h00) & ~loaded_r & txPending);

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         seq_r <= spp_pkg::SEQ_IDLE;
      end else begin
         unique case (seq_r)
            spp_pkg::SEQ_IDLE: begin
               if (!cfgFramed && (!cfgMaster || txPending)) begin
                  seq_r <= spp_pkg::SEQ_RUN;
               end else if (cfgFramed && lead && frameReq) begin
                  seq_r <= spp_pkg::SEQ_SYNC;
               end
            end
            spp_pkg::SEQ_SYNC: begin
               if (lead) begin
                  seq_r <= spp_pkg::SEQ_RUN;
               end
            end
            spp_pkg::SEQ_RUN: begin
               if (cfgFramed ? wordDone : cfgMaster & tick & (kCnt_r == {wordLen, 1'h0})) begin
                  seq_r <= spp_pkg::SEQ_IDLE;
               end
            end
            default: seq_r <= spp_pkg::SEQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         halfCnt_r <= 6'h00;
         kCnt_r <= 6'h00;
         sckOut_r <= 1'h0;
      end else if (cfgMaster && (cfgFramed || inWord)) begin
         if (tick) begin
            halfCnt_r <= 6'(spp_pkg::LINK_HALF_CYC - 1);
            kCnt_r <= kCnt_r + 6'h01;
            if (cfgFramed || kCnt_r < {wordLen, 1'h0}) begin
               sckOut_r <= ~sckOut_r;
            end
         end else begin
            halfCnt_r <= halfCnt_r - 6'h01;
         end
      end else begin
         halfCnt_r <= 6'(spp_pkg::LINK_HALF_CYC - 1);
         kCnt_r <= 6'h00;
         sckOut_r <= cfgCpol;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         txHold_r <= spp_pkg::WORD_RESET;
         txPending <= 1'h0;
         txShift_r <= spp_pkg::WORD_RESET;
         rxShift_r <= spp_pkg::WORD_RESET;
         bitCnt_r <= 5'h00;
         loaded_r <= 1'h0;
         rxWord <= spp_pkg::WORD_RESET;
         rxValid <= 1'h0;
      end else begin
         if (txLoad) begin
            txHold_r <= txWord;
         end
         txPending <= txLoad | (txPending & ~loadTx);
         if (loadTx) begin
            txShift_r <= txPending ? txHold_r : spp_pkg::WORD_RESET;
            loaded_r <= 1'h1;
         end else if (changeEv && (bitCnt_r != 5'h00 || sampleEv)) begin
            txShift_r <= {txShift_r[14:0], 1'h0};
         end
         if (sampleEv) begin
            rxShift_r <= {rxShift_r[14:0], sdiSync_r[1]};
            bitCnt_r <= wordDone ? 5'h00 : bitCnt_r + 5'h01;
         end
         if (wordDone) begin
            loaded_r <= 1'h0;
            rxWord <= cfgWide ? {rxShift_r[14:0], sdiSync_r[1]} : {8'h00, rxShift_r[6:0], sdiSync_r[1]};
         end
         rxValid <= wordDone;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ssOut_r <= 1'h1;
         sdo_r <= 1'h0;
      end else begin
         if (cfgFramed) begin
            if (lead) begin
               ssOut_r <= ((seq_r == spp_pkg::SEQ_IDLE) & frameReq) ? cfgSyncPol : ~cfgSyncPol;
            end
         end else begin
            ssOut_r <= ~inWord;
         end
         sdo_r <= cfgWide ? txShift_r[15] : txShift_r[7];
      end
   end

   assign link.partSckO = sckOut_r;
   assign link.partSckOeN = ~cfgMaster;
   assign link.partSdo = sdo_r;
   assign link.partSdoOeN = 1'h0;
   assign link.partSsO = ssOut_r;
   assign link.partSsOeN = ~(cfgMaster & (cfgFramed | cfgUseSelect));
endmodule : spp_partner_end

//--- tb/spp_properties.sv
`timescale 1ns/1ps
module spp_properties (
   input wire logic clock, // module clock
   input wire logic nrst, // async reset
   input wire logic sck, // resolved clock
   input wire logic ss, // resolved select
   input wire logic partSdi, // data to partner
   input wire logic devSckOeN, // device clock enable
   input wire logic devSsOeN, // device select enable
   input wire logic partSckOeN // partner clock enable
);
   logic [5:0] togCnt_r;
   logic idleLvl_r;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // edges seen inside a select window; cleared at each window start
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) togCnt_r <= 6'h00;
      else if ($fell(ss)) togCnt_r <= 6'h00;
      else if (!ss && $changed(sck)) togCnt_r <= togCnt_r + 6'h01;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) idleLvl_r <= 1'b0;
      else if ($fell(ss)) idleLvl_r <= sck;
   end
   sequence s_quiet;
      $stable(sck)[*3];
   endsequence
   property p_spacing;
      !devSckOeN && $past(devSckOeN) == 1'b0 && $changed(sck) |=> s_quiet;
   endproperty
   a_spacing: assert property (p_spacing) else $error("link clock edges too close");
   property p_inFrame;
      !devSsOeN && $past(devSckOeN) == 1'b0 && $changed(sck) |-> !ss;
   endproperty
   a_inFrame: assert property (p_inFrame) else $error("clock edge outside select");
   property p_leadIn;
      $fell(ss) && !devSckOeN |-> s_quiet;
   endproperty
   a_leadIn: assert property (p_leadIn) else $error("clock moved at frame start");
   property p_dataStable;
      !ss && $changed(sck) |-> $stable(partSdi);
   endproperty
   a_dataStable: assert property (p_dataStable) else $error("data moved on clock edge");
   property p_frameHold;
      $fell(ss) |=> !ss [*8];
   endproperty
   a_frameHold: assert property (p_frameHold) else $error("select pulse too short");
   property p_toggles;
      $rose(ss) && !devSsOeN |-> togCnt_r == 6'h10 || togCnt_r == 6'h20;
   endproperty
   a_toggles: assert property (p_toggles) else $error("wrong edge count per word");
   property p_idleLevel;
      $rose(ss) && !devSsOeN |-> sck == idleLvl_r;
   endproperty
   a_idleLevel: assert property (p_idleLevel) else $error("clock not at idle level");
   property p_oneDriver;
      !devSckOeN |-> partSckOeN;
   endproperty
   a_oneDriver: assert property (p_oneDriver) else $error("two clock drivers");
endmodule : spp_properties

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic idleMode = 1'b0;
   logic [1:0] regAddr = 2'h0;
   logic [15:0] regWdata = 16'h0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [15:0] regRdata;
   logic cfgWide = 1'b0;
   logic cfgCpol = 1'b0;
   logic cfgEdge = 1'b1;
   logic cfgUseSelect = 1'b1;
   logic [15:0] txWord = 16'h0000;
   logic txLoad = 1'b0;
   logic [15:0] rxWord;
   logic rxValid;
   int errors = 0;
   int n_compared = 0;
   spp_link_if link ();
   always #20 clock = ~clock;
   spp_device_end i_spp_device_end (.clock(clock), .nrst(nrst), .idleMode(idleMode), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .link(link.dev));
   spp_partner_end i_spp_partner_end (.clock(clock), .nrst(nrst), .cfgMaster(1'b0), .cfgCpol(cfgCpol),
      .cfgEdge(cfgEdge), .cfgWide(cfgWide), .cfgFramed(1'b0), .cfgSyncPol(1'b0), .cfgUseSelect(cfgUseSelect),
      .txWord(txWord), .txLoad(txLoad), .txPending(), .rxWord(rxWord), .rxValid(rxValid), .link(link.part));
   spp_properties i_spp_properties (.clock(clock), .nrst(nrst), .sck(link.sck), .ss(link.ss),
      .partSdi(link.partSdi), .devSckOeN(link.devSckOeN), .devSsOeN(link.devSsOeN), .partSckOeN(link.partSckOeN));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // write ends one edge later so back-to-back calls never re-assign the strobe in one step
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [15:0] exp);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      @(posedge clock);
      check(regRdata, exp);
   endtask : rd
   task automatic load(input logic [15:0] w);
      txWord <= w;
      txLoad <= 1'b1;
      @(posedge clock);
      txLoad <= 1'b0;
   endtask : load
   task automatic finish(input logic [15:0] exp);
      repeat (2000) begin
         @(posedge clock);
         if (rxValid === 1'b1) break;
      end
      // a wait that ran out leaves the pulse low here and counts as a mismatch
      check({15'h0000, rxValid}, 16'h0001);
      check(rxWord & (cfgWide ? 16'hFFFF : 16'h00FF), exp);
      repeat (12) @(posedge clock);
   endtask : finish
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   initial begin
      #3000000;
      errors++;
      stop_test;
   end
   initial begin
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      for (int a = 0; a < 3; a++) rd(a[1:0], 16'h0000);
      wr(spp_pkg::OFS_CTRL1, 16'h0200);
      rd(spp_pkg::OFS_CTRL1, 16'h0000);
      wr(spp_pkg::OFS_CTRL1, 16'h03A0);
      rd(spp_pkg::OFS_CTRL1, 16'h03A0);
      load(16'h005A);
      wr(spp_pkg::OFS_DATA, 16'h00C3);
      rd(spp_pkg::OFS_STATUS, 16'h0002);
      wr(spp_pkg::OFS_STATUS, 16'hFFFF);
      finish(16'h00C3);
      rd(spp_pkg::OFS_STATUS, 16'hA001);
      rd(spp_pkg::OFS_DATA, 16'h005A);
      rd(spp_pkg::OFS_STATUS, 16'hA000);
      $display("basic word done");
      load(16'h0011);
      wr(spp_pkg::OFS_DATA, 16'h0022);
      finish(16'h0022);
      load(16'h0033);
      wr(spp_pkg::OFS_DATA, 16'h0044);
      finish(16'h0044);
      rd(spp_pkg::OFS_STATUS, 16'hA041);
      rd(spp_pkg::OFS_DATA, 16'h0011);
      wr(spp_pkg::OFS_STATUS, 16'hA000);
      rd(spp_pkg::OFS_STATUS, 16'hA000);
      $display("overflow done");
      idleMode <= 1'b1;
      load(16'h0066);
      wr(spp_pkg::OFS_DATA, 16'h0077);
      repeat (200) @(posedge clock);
      rd(spp_pkg::OFS_STATUS, 16'hA002);
      idleMode <= 1'b0;
      finish(16'h0077);
      rd(spp_pkg::OFS_DATA, 16'h0066);
      $display("idle stop done");
      cfgWide <= 1'b1;
      wr(spp_pkg::OFS_CTRL1, 16'h07A0);
      load(16'hA55A);
      wr(spp_pkg::OFS_DATA, 16'h5AA5);
      finish(16'h5AA5);
      rd(spp_pkg::OFS_DATA, 16'hA55A);
      $display("wide word done");
      // polarity is changed only while disabled, so no stray clock edge reaches the link
      wr(spp_pkg::OFS_STATUS, 16'h0000);
      rd(spp_pkg::OFS_STATUS, 16'h0000);
      cfgCpol <= 1'b1;
      cfgEdge <= 1'b0;
      wr(spp_pkg::OFS_CTRL1, 16'h06E0);
      wr(spp_pkg::OFS_STATUS, 16'h8000);
      load(16'h1234);
      wr(spp_pkg::OFS_DATA, 16'hFEDC);
      finish(16'hFEDC);
      rd(spp_pkg::OFS_DATA, 16'h1234);
      $display("polarity and edge done");
      stop_test;
   end
endmodule : testbench
